/* core/l1dc_pkg.sv */
// Shared constants, types and address decoding for the level-one data cache.
// Assumes one core clock; addresses are word addresses into level2_memory.
package l1dc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Geometry
   localparam int WORD_W = 32;
   localparam int LINE_BYTES = 64;
   localparam int LINE_WORDS = LINE_BYTES / (WORD_W / 8);
   localparam int OFF_W = 4;
   localparam int WAYS = 2;
   localparam int IDX_W = 2;
   localparam int SETS = 4;
   localparam int TAG_W = 2;
   localparam int LADDR_W = IDX_W + TAG_W;
   localparam int ADDR_W = LADDR_W + OFF_W;
   localparam int SLOT_W = 1 + IDX_W;
   localparam int SLOTS = WAYS * SETS;
   localparam int L1_WORDS = SLOTS * LINE_WORDS;
   localparam int L2_WORDS = 256;
   localparam int CNT_W = 5;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and fixed codes
   localparam logic [OFF_W-1:0] LAST_WORD = 4'hF;
   localparam logic [OFF_W-1:0] FIRST_WORD = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
   localparam logic [LADDR_W-1:0] LINE_ZERO = 4'h0;
   localparam logic [WORD_W-1:0] WORD_ZERO = 32'h00000000;

   typedef logic [ADDR_W-1:0] l1dc_addr_t;
   typedef logic [WORD_W-1:0] l1dc_word_t;
   typedef logic [LADDR_W-1:0] l1dc_line_t;
   typedef logic [SLOT_W-1:0] l1dc_slot_t;

   typedef struct packed {
      logic we;
      l1dc_addr_t addr;
      l1dc_word_t wdata;
   } l1dc_req_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FILL = 2'b01,
      ST_WBINV = 2'b10,
      ST_DRAIN = 2'b11
   } l1dc_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // Address decoding
   function automatic l1dc_line_t f_line(input l1dc_addr_t a);
      return a[ADDR_W-1:OFF_W];
   endfunction : f_line

   function automatic logic [IDX_W-1:0] f_lidx(input l1dc_line_t l);
      return l[IDX_W-1:0];
   endfunction : f_lidx

   function automatic logic [TAG_W-1:0] f_ltag(input l1dc_line_t l);
      return l[LADDR_W-1:IDX_W];
   endfunction : f_ltag

   function automatic logic [OFF_W-1:0] f_off(input l1dc_addr_t a);
      return a[OFF_W-1:0];
   endfunction : f_off

endpackage : l1dc_pkg

/* core/l1dc_l2ram.sv */
// Level2_memory RAM array: one read port, one write port.
// Assumes the owner arbitrates both ports; read data is combinational.
`timescale 1ns/100ps
module l1dc_l2ram
   import l1dc_pkg::*;
(
   input wire logic clk,
   input wire l1dc_addr_t rd_addr,
   output l1dc_word_t rd_data,
   input wire logic wr_en,
   input wire l1dc_addr_t wr_addr,
   input wire l1dc_word_t wr_data
);

   l1dc_word_t mem [0:L2_WORDS-1];

   // Storage only, so no reset: contents are undefined until written
   assign rd_data = mem[rd_addr];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

endmodule : l1dc_l2ram

/* core/l1dc_cache.sv */
// Level1_data_cache with level2_memory and slave_dma_port coherence.
// Assumes cpu and dma requesters on the same clock, holding a request
// stable until ready. Config straps are levels from same-clock logic.
//
// Notes on behaviour
// - Two-way set associative; a line can sit in one of two ways.
// - Lines are 64 bytes; fill, eviction and write-back move whole lines.
// - Only cpu read misses allocate; write misses go straight to level2.
// - Cpu writes to a cached line mark it dirty and stay in cache.
// - Dirty data reaches level2 only on eviction or explicit write-back.
// - A read allocating over a dirty line evicts it as a victim write-back.
// - Slave_dma_port reads and writes reach level2_memory RAM.
// - Write-back-invalidate of a line range, optionally waiting for drain.
// - Level2 all-cache mode: no RAM addressable, dma accesses error.
// - Level1 all-RAM mode: nothing is cached, cpu goes to memory.
// - Victims are handed to the level2 controller through a buffer.
// - Victim drain and line fill proceed concurrently; dma writes wait for the drain.
`timescale 1ns/100ps
module l1dc_cache
   import l1dc_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic l1_all_ram,
   input wire logic l2_all_cache,
   input wire logic cpu_req,
   input wire l1dc_req_t cpu_in,
   output logic cpu_ready,
   output logic cpu_rvalid,
   output l1dc_word_t cpu_rdata,
   input wire logic dma_req,
   input wire l1dc_req_t dma_in,
   output logic dma_ready,
   output logic dma_rvalid,
   output l1dc_word_t dma_rdata,
   output logic dma_err,
   input wire logic wbinv_req,
   input wire l1dc_line_t wbinv_line,
   input wire logic [CNT_W-1:0] wbinv_count,
   input wire logic wbinv_wait,
   output logic wbinv_busy,
   output logic wbinv_done
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   l1dc_state_t state, next_state;
   logic valid [0:SLOTS-1];
   logic dirty [0:SLOTS-1];
   logic [TAG_W-1:0] tagm [0:SLOTS-1];
   logic lru [0:SETS-1];
   l1dc_word_t l1_mem [0:L1_WORDS-1];
   logic vb_valid;
   l1dc_line_t vb_line;
   logic [OFF_W-1:0] vb_cnt;
   l1dc_word_t vb_data [0:LINE_WORDS-1];
   logic fill_way;
   l1dc_line_t fill_line;
   logic [OFF_W-1:0] fill_cnt;
   l1dc_line_t wb_line;
   logic [CNT_W-1:0] wb_left;
   logic wb_wait;

   ////////////////////////////////////////////////////////////////////////////
   // Tag lookups for cpu, dma and write-back walker
   l1dc_line_t cpu_line, dma_line;
   logic [WAYS-1:0] cpu_hit, dma_hit, wb_hit;
   assign cpu_line = f_line(cpu_in.addr);
   assign dma_line = f_line(dma_in.addr);

   genvar gw;
   generate
      for (gw = 0; gw < WAYS; gw++) begin : g_way
         assign cpu_hit[gw] = valid[{1'(gw), f_lidx(cpu_line)}]
            && tagm[{1'(gw), f_lidx(cpu_line)}] == f_ltag(cpu_line);
         assign dma_hit[gw] = valid[{1'(gw), f_lidx(dma_line)}]
            && tagm[{1'(gw), f_lidx(dma_line)}] == f_ltag(dma_line);
         assign wb_hit[gw] = valid[{1'(gw), f_lidx(wb_line)}]
            && tagm[{1'(gw), f_lidx(wb_line)}] == f_ltag(wb_line);
      end
   endgenerate

   l1dc_slot_t cpu_hslot, dma_hslot, wb_hslot, vslot, fslot;
   logic vway, vdirty, wb_dirty;
   assign cpu_hslot = {cpu_hit[1], f_lidx(cpu_line)};
   assign dma_hslot = {dma_hit[1], f_lidx(dma_line)};
   assign wb_hslot = {wb_hit[1], f_lidx(wb_line)};
   assign fslot = {fill_way, f_lidx(fill_line)};
   // Free way first, else the least recently used one
   assign vway = !valid[{1'b0, f_lidx(cpu_line)}] ? 1'b0 :
                 !valid[{1'b1, f_lidx(cpu_line)}] ? 1'b1 :
                 lru[f_lidx(cpu_line)];
   assign vslot = {vway, f_lidx(cpu_line)};
   assign vdirty = valid[vslot] && dirty[vslot];
   assign wb_dirty = (|wb_hit) && dirty[wb_hslot];

   ////////////////////////////////////////////////////////////////////////////
   // Cpu side decode
   logic idle, cached, cpu_vb_clash;
   logic cpu_rd_hit, cpu_wr_hit, cpu_miss_go, cpu_l2_wr, cpu_l2_rd;
   logic cpu_l1_wr, fill_we, fill_end;
   assign idle = (state == ST_IDLE) && !wbinv_req;
   assign cached = !l1_all_ram;
   // A line still in the victim buffer is newer than its level2 copy
   assign cpu_vb_clash = vb_valid && (cpu_line == vb_line);
   assign cpu_rd_hit = idle && cpu_req && !cpu_in.we && cached
      && (|cpu_hit);
   assign cpu_wr_hit = idle && cpu_req && cpu_in.we && cached && (|cpu_hit);
   assign cpu_miss_go = idle && cpu_req && !cpu_in.we && cached
      && !(|cpu_hit) && !cpu_vb_clash && !(vdirty && vb_valid);
   // Write misses never allocate; they go out once the drain is idle
   assign cpu_l2_wr = idle && cpu_req && cpu_in.we
      && !(cached && (|cpu_hit)) && !vb_valid;
   assign cpu_l2_rd = idle && cpu_req && !cpu_in.we && !cached
      && !cpu_vb_clash;
   assign cpu_l1_wr = cpu_wr_hit;
   assign cpu_ready = cpu_rd_hit || cpu_wr_hit || cpu_l2_wr || cpu_l2_rd;
   assign fill_we = (state == ST_FILL);
   assign fill_end = fill_we && (fill_cnt == LAST_WORD);

   ////////////////////////////////////////////////////////////////////////////
   // Write-back-invalidate walker
   logic wb_start, wb_step, wb_fin;
   assign wb_start = (state == ST_IDLE) && wbinv_req;
   assign wb_step = (state == ST_WBINV) && (wb_left != CNT_ZERO)
      && !(wb_dirty && vb_valid);
   assign wb_fin = ((state == ST_WBINV) && (wb_left == CNT_ZERO) && !wb_wait)
      || ((state == ST_DRAIN) && !vb_valid);
   assign wbinv_busy = (state == ST_WBINV) || (state == ST_DRAIN);

   ////////////////////////////////////////////////////////////////////////////
   // Victim buffer load: eviction or explicit write-back
   logic vb_load;
   l1dc_slot_t vb_src;
   l1dc_line_t vb_src_line;
   assign vb_load = (cpu_miss_go && vdirty) || (wb_step && wb_dirty);
   assign vb_src = wb_step ? wb_hslot : vslot;
   assign vb_src_line = wb_step ? wb_line : {tagm[vslot], f_lidx(cpu_line)};

   ////////////////////////////////////////////////////////////////////////////
   // Dma side decode
   logic dma_fill_clash, dma_vb_hit, dma_rd_go, dma_wr_go, dma_go;
   logic dma_l1_wr, dma_l2_rd;
   // Neither the line being filled nor the victim may take a write
   assign dma_fill_clash = fill_we && (dma_line == fill_line);
   assign dma_vb_hit = vb_valid && (dma_line == vb_line);
   assign dma_l2_rd = !dma_vb_hit && !(|dma_hit);
   assign dma_rd_go = !dma_in.we && !dma_fill_clash
      && !(dma_l2_rd && (fill_we || cpu_l2_rd));
   // A victim copy taken this cycle would miss a dma write to its line
   assign dma_wr_go = dma_in.we && !dma_fill_clash && !vb_valid
      && !cpu_l2_wr && !cpu_l1_wr && !vb_load;
   assign dma_go = dma_req && !l2_all_cache && (dma_rd_go || dma_wr_go);
   assign dma_ready = dma_req && (l2_all_cache || dma_go);
   assign dma_l1_wr = dma_go && dma_in.we && (|dma_hit);

   ////////////////////////////////////////////////////////////////////////////
   // Level2 port arbitration: drain > cpu > dma on the write port
   l1dc_addr_t l2_rd_addr, l2_wr_addr;
   l1dc_word_t l2_rd_data, l2_wr_data;
   logic l2_wr_en;
   assign l2_rd_addr = fill_we ? {fill_line, fill_cnt} :
                       cpu_l2_rd ? cpu_in.addr : dma_in.addr;
   assign l2_wr_en = vb_valid || cpu_l2_wr || (dma_go && dma_in.we);
   assign l2_wr_addr = vb_valid ? {vb_line, vb_cnt} :
                       cpu_l2_wr ? cpu_in.addr : dma_in.addr;
   assign l2_wr_data = vb_valid ? vb_data[vb_cnt] :
                       cpu_l2_wr ? cpu_in.wdata : dma_in.wdata;

   l1dc_l2ram u_l2ram (
      .clk(clk),
      .rd_addr(l2_rd_addr),
      .rd_data(l2_rd_data),
      .wr_en(l2_wr_en),
      .wr_addr(l2_wr_addr),
      .wr_data(l2_wr_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (wbinv_req) begin
               next_state = ST_WBINV;
            end else if (cpu_miss_go) begin
               next_state = ST_FILL;
            end
         end
         ST_FILL: begin
            if (fill_end) begin
               next_state = ST_IDLE;
            end
         end
         ST_WBINV: begin
            if (wb_left == CNT_ZERO) begin
               next_state = wb_wait ? ST_DRAIN : ST_IDLE;
            end
         end
         ST_DRAIN: begin
            if (!vb_valid) begin
               next_state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fill and walker registers
   always_ff @(posedge clk) begin
      if (!nrst) begin
         fill_way <= 1'b0;
         fill_line <= LINE_ZERO;
         fill_cnt <= FIRST_WORD;
      end else if (cpu_miss_go) begin
         fill_way <= vway;
         fill_line <= cpu_line;
         fill_cnt <= FIRST_WORD;
      end else if (fill_we) begin
         fill_cnt <= fill_cnt + 4'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         wb_line <= LINE_ZERO;
         wb_left <= CNT_ZERO;
         wb_wait <= 1'b0;
      end else if (wb_start) begin
         wb_line <= wbinv_line;
         wb_left <= wbinv_count;
         wb_wait <= wbinv_wait;
      end else if (wb_step) begin
         wb_line <= wb_line + 4'h1;
         wb_left <= wb_left - 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Tag, valid, dirty and replacement state
   always_ff @(posedge clk) begin
      if (!nrst) begin
         for (int i = 0; i < SLOTS; i++) begin
            valid[i] <= 1'b0;
            dirty[i] <= 1'b0;
            tagm[i] <= '0;
         end
         for (int s = 0; s < SETS; s++) begin
            lru[s] <= 1'b0;
         end
      end else begin
         if (cpu_miss_go) begin
            valid[vslot] <= 1'b0;
            dirty[vslot] <= 1'b0;
         end
         if (fill_end) begin
            valid[fslot] <= 1'b1;
            dirty[fslot] <= 1'b0;
            tagm[fslot] <= f_ltag(fill_line);
            lru[f_lidx(fill_line)] <= !fill_way;
         end
         if (cpu_wr_hit) begin
            dirty[cpu_hslot] <= 1'b1;
         end
         if (cpu_rd_hit || cpu_wr_hit) begin
            lru[f_lidx(cpu_line)] <= !cpu_hit[1];
         end
         if (wb_step && (|wb_hit)) begin
            valid[wb_hslot] <= 1'b0;
            dirty[wb_hslot] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Line storage; the fill slot is invalid so dma never writes it
   always_ff @(posedge clk) begin
      if (fill_we) begin
         l1_mem[{fslot, fill_cnt}] <= l2_rd_data;
      end
      if (cpu_l1_wr) begin
         l1_mem[{cpu_hslot, f_off(cpu_in.addr)}] <= cpu_in.wdata;
      end
      if (dma_l1_wr) begin
         l1_mem[{dma_hslot, f_off(dma_in.addr)}] <= dma_in.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Victim buffer: whole line copied at once, drained one word a cycle
   always_ff @(posedge clk) begin
      if (!nrst) begin
         vb_valid <= 1'b0;
         vb_line <= LINE_ZERO;
         vb_cnt <= FIRST_WORD;
      end else if (vb_load) begin
         vb_valid <= 1'b1;
         vb_line <= vb_src_line;
         vb_cnt <= FIRST_WORD;
      end else if (vb_valid) begin
         vb_cnt <= vb_cnt + 4'h1;
         if (vb_cnt == LAST_WORD) begin
            vb_valid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (vb_load) begin
         for (int i = 0; i < LINE_WORDS; i++) begin
            vb_data[i] <= l1_mem[{vb_src, 4'(i)}];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Answers
   l1dc_word_t dma_word, cpu_word;
   assign dma_word = dma_vb_hit ? vb_data[f_off(dma_in.addr)] :
                     (|dma_hit) ? l1_mem[{dma_hslot, f_off(dma_in.addr)}] :
                     l2_rd_data;
   assign cpu_word = cpu_rd_hit ? l1_mem[{cpu_hslot, f_off(cpu_in.addr)}] :
                     l2_rd_data;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         cpu_rvalid <= 1'b0;
         cpu_rdata <= WORD_ZERO;
         dma_rvalid <= 1'b0;
         dma_rdata <= WORD_ZERO;
         dma_err <= 1'b0;
         wbinv_done <= 1'b0;
      end else begin
         cpu_rvalid <= cpu_rd_hit || cpu_l2_rd;
         cpu_rdata <= cpu_word;
         dma_rvalid <= dma_go && !dma_in.we;
         dma_rdata <= dma_word;
         dma_err <= dma_req && l2_all_cache;
         wbinv_done <= wb_fin;
      end
   end

endmodule : l1dc_cache

/* bench/l1dc_cache_asserts.sv */
// Port-level assertions for the level1_data_cache top module.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module l1dc_cache_asserts
   import l1dc_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic l1_all_ram,
   input wire logic l2_all_cache,
   input wire logic cpu_req,
   input wire l1dc_req_t cpu_in,
   input wire logic cpu_ready,
   input wire logic cpu_rvalid,
   input wire l1dc_word_t cpu_rdata,
   input wire logic dma_req,
   input wire l1dc_req_t dma_in,
   input wire logic dma_ready,
   input wire logic dma_rvalid,
   input wire l1dc_word_t dma_rdata,
   input wire logic dma_err,
   input wire logic wbinv_req,
   input wire l1dc_line_t wbinv_line,
   input wire logic [CNT_W-1:0] wbinv_count,
   input wire logic wbinv_wait,
   input wire logic wbinv_busy,
   input wire logic wbinv_done
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////////////
   sequence s_cpu_rd;
      cpu_req && cpu_ready && !cpu_in.we;
   endsequence
   sequence s_cpu_wr;
      cpu_req && cpu_ready && cpu_in.we;
   endsequence
   sequence s_dma_rd;
      dma_req && dma_ready && !dma_in.we && !l2_all_cache;
   endsequence
   sequence s_dma_bad;
      dma_req && dma_ready && l2_all_cache;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   a_cpu_rd_answer: assert property (s_cpu_rd |=> cpu_rvalid)
      else $error("cpu read taken but no answer");
   a_cpu_wr_quiet: assert property (s_cpu_wr |=> !cpu_rvalid)
      else $error("cpu write produced read data");
   a_rvalid_cause: assert property (
      cpu_rvalid |-> $past(cpu_req && cpu_ready && !cpu_in.we))
      else $error("cpu read data without a taken read");
   a_dma_rd_answer: assert property (
      s_dma_rd |=> dma_rvalid && !dma_err)
      else $error("dma read not answered");
   a_dma_err_mode: assert property (
      s_dma_bad |=> dma_err && !dma_rvalid)
      else $error("dma access in all-cache mode not refused");
   a_err_cause: assert property (
      dma_err |-> $past(dma_req && dma_ready && l2_all_cache))
      else $error("dma error without cause");
   a_done_pulse: assert property (
      wbinv_done |-> $past(wbinv_busy) ##1 !wbinv_done)
      else $error("write-back done not a single pulse after busy");
   a_busy_start: assert property ($rose(wbinv_busy) |-> $past(wbinv_req))
      else $error("write-back busy without request");
   a_busy_blocks_cpu: assert property (wbinv_busy |-> !cpu_ready)
      else $error("cpu taken during write-back walk");
   a_wbinv_bounded: assert property (
      $rose(wbinv_busy) |-> ##[1:700] wbinv_done)
      else $error("write-back never completed");
   // Covers fill, victim drain and write-miss order waits together
   a_stall_bounded: assert property (
      cpu_req && !cpu_ready && !wbinv_busy |->
      ##[1:80] (cpu_ready || !cpu_req || wbinv_busy))
      else $error("cpu stall too long");
endmodule : l1dc_cache_asserts

bind l1dc_cache l1dc_cache_asserts u_chk (.clk(clk), .nrst(nrst),
   .l1_all_ram(l1_all_ram), .l2_all_cache(l2_all_cache),
   .cpu_req(cpu_req), .cpu_in(cpu_in), .cpu_ready(cpu_ready),
   .cpu_rvalid(cpu_rvalid), .cpu_rdata(cpu_rdata), .dma_req(dma_req),
   .dma_in(dma_in), .dma_ready(dma_ready), .dma_rvalid(dma_rvalid),
   .dma_rdata(dma_rdata), .dma_err(dma_err), .wbinv_req(wbinv_req),
   .wbinv_line(wbinv_line), .wbinv_count(wbinv_count),
   .wbinv_wait(wbinv_wait), .wbinv_busy(wbinv_busy),
   .wbinv_done(wbinv_done));

/* bench/l1dc_dma_model.sv */
// Slave_dma_port requester model: one word transfer at a time.
// Assumes the cache takes a request on a rising edge with ready high.
`timescale 1ns/100ps
module l1dc_dma_model
   import l1dc_pkg::*;
(
   output logic dma_req,
   output l1dc_req_t dma_in,
   input wire logic clk,
   input wire logic dma_ready,
   input wire logic dma_rvalid,
   input wire l1dc_word_t dma_rdata,
   input wire logic dma_err
);
   initial begin
      dma_req = 1'h0;
      dma_in = '0;
   end
   // g + 1 idle cycles first, so the master can be prompt or slow
   task automatic xfer(input logic we, input l1dc_addr_t a,
      input l1dc_word_t d, input int g, output l1dc_word_t q,
      output logic [1:0] st, output logic to);
      int n;
      n = 0;
      repeat (g + 1) @(negedge clk);
      dma_req = 1'h1;
      dma_in = '{we, a, d};
      // Ready is judged on the rising edge that takes the request
      @(posedge clk);
      while (dma_ready !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      @(negedge clk);
      to = (n >= 200);
      st = {dma_err, dma_rvalid};
      q = dma_rdata;
      dma_req = 1'h0;
      // Released bus inverted so nothing leans on stale values
      dma_in = ~dma_in;
   endtask : xfer
endmodule : l1dc_dma_model

/* bench/tb.sv */
// Self-checking bench for l1dc_cache with a dma requester model.
// Assumes 125 MHz clock; all inputs move on the falling edge.
`timescale 1ns/100ps
module tb;
   import l1dc_pkg::*;
   logic clk = 1'h0, nrst = 1'h0, l1_all_ram = 1'h0, l2_all_cache = 1'h0;
   logic cpu_req = 1'h0, wbinv_req = 1'h0, wbinv_wait = 1'h0;
   l1dc_req_t cpu_in = '0;
   l1dc_req_t dma_in;
   l1dc_line_t wbinv_line = 4'h0;
   logic [CNT_W-1:0] wbinv_count = 5'h00;
   logic cpu_ready, cpu_rvalid, dma_req, dma_ready, dma_rvalid, dma_err;
   logic wbinv_busy, wbinv_done;
   l1dc_word_t cpu_rdata, dma_rdata;
   int n_mismatch = 0, compares = 0;
   always #4 clk = ~clk;
   l1dc_cache uut (.clk(clk), .nrst(nrst), .l1_all_ram(l1_all_ram),
      .l2_all_cache(l2_all_cache), .cpu_req(cpu_req), .cpu_in(cpu_in),
      .cpu_ready(cpu_ready), .cpu_rvalid(cpu_rvalid), .cpu_rdata(cpu_rdata),
      .dma_req(dma_req), .dma_in(dma_in), .dma_ready(dma_ready),
      .dma_rvalid(dma_rvalid), .dma_rdata(dma_rdata), .dma_err(dma_err),
      .wbinv_req(wbinv_req), .wbinv_line(wbinv_line),
      .wbinv_count(wbinv_count), .wbinv_wait(wbinv_wait),
      .wbinv_busy(wbinv_busy), .wbinv_done(wbinv_done));
   l1dc_dma_model u_dma (.clk(clk), .dma_req(dma_req), .dma_in(dma_in),
      .dma_ready(dma_ready), .dma_rvalid(dma_rvalid),
      .dma_rdata(dma_rdata), .dma_err(dma_err));
   ////////////////////////////////////////////////////////////////////////
   function automatic l1dc_word_t f_init(input l1dc_addr_t a);
      return {24'h5A5A00, a};
   endfunction : f_init
   task automatic stop_test;
      $display("compares=%0d mismatches=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test
   task automatic hang;
      n_mismatch++;
      $display("CHECK FAILED t=%0t wait bound used up", $time);
      stop_test();
   endtask : hang
   task automatic chk_w(input l1dc_word_t got, input l1dc_word_t exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_w
   task automatic chk_f(input logic [3:0] got, input logic [3:0] exp);
      chk_w({28'h0000000, got}, {28'h0000000, exp});
   endtask : chk_f
   task automatic chk_lat(input int got, input int lo, input int hi);
      compares++;
      if (got < lo || got > hi) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, lo);
      end
   endtask : chk_lat
   ////////////////////////////////////////////////////////////////////////
   task automatic cpu_op(input logic we, input l1dc_addr_t a,
      input l1dc_word_t d, output l1dc_word_t q, output int lat);
      lat = 0;
      @(negedge clk);
      cpu_req = 1'h1;
      cpu_in = '{we, a, d};
      @(posedge clk);
      while (cpu_ready !== 1'b1) begin
         lat++;
         if (lat > 200) hang();
         @(posedge clk);
      end
      @(negedge clk);
      q = (cpu_rvalid === 1'b1) ? cpu_rdata : 32'hXXXXXXXX;
      cpu_req = 1'h0;
      cpu_in = ~cpu_in;
   endtask : cpu_op
   task automatic dma(input logic we, input l1dc_addr_t a,
      input l1dc_word_t d, input int g, output l1dc_word_t q,
      output logic [1:0] st);
      logic to;
      u_dma.xfer(we, a, d, g, q, st, to);
      if (to) hang();
   endtask : dma
   task automatic wbinv(input logic [CNT_W-1:0] c, input logic w,
      output int n);
      n = 0;
      @(negedge clk);
      wbinv_req = 1'h1;
      wbinv_line = 4'h0;
      wbinv_count = c;
      wbinv_wait = w;
      while (wbinv_busy !== 1'b1 && wbinv_done !== 1'b1) begin
         @(negedge clk);
         if (++n > 8) hang();
      end
      wbinv_req = 1'h0;
      while (wbinv_done !== 1'b1) begin
         @(negedge clk);
         if (++n > 700) hang();
      end
   endtask : wbinv
   ////////////////////////////////////////////////////////////////////////
   task automatic t_load;
      l1dc_word_t q;
      logic [1:0] st;
      // Lines 0x10, 0x50, 0x90 share set 1; whole aligned lines only
      for (int i = 0; i < 48; i++)
         dma(1'h1, 8'h10 + 8'((i / 16) * 64 + i % 16),
            f_init(8'h10 + 8'((i / 16) * 64 + i % 16)), i % 3, q, st);
      dma(1'h0, 8'h9F, 32'h00000000, 0, q, st);
      chk_w(q, f_init(8'h9F));
      chk_f({2'h0, st}, 4'h1);
   endtask : t_load
   task automatic t_alloc_evict;
      l1dc_word_t q, q2;
      int lat, lat2;
      logic [1:0] st;
      cpu_op(1'h0, 8'h13, 32'h00000000, q, lat);
      chk_lat(lat, 16, 40);
      chk_w(q, f_init(8'h13));
      cpu_op(1'h0, 8'h1F, 32'h00000000, q, lat);
      chk_lat(lat, 0, 0);
      cpu_op(1'h0, 8'h52, 32'h00000000, q, lat);
      chk_w(q, f_init(8'h52));
      cpu_op(1'h0, 8'h10, 32'h00000000, q, lat);
      chk_lat(lat, 0, 0);
      cpu_op(1'h1, 8'h13, 32'hD1D1D1D1, q, lat);
      chk_lat(lat, 0, 0);
      cpu_op(1'h0, 8'h90, 32'h00000000, q, lat);
      chk_lat(lat, 16, 40);
      // Dirty line 0x10 is the victim; dma writes the incoming line
      fork
         cpu_op(1'h0, 8'h55, 32'h00000000, q2, lat2);
         begin
            dma(1'h0, 8'h13, 32'h00000000, 1, q, st);
            chk_w(q, 32'hD1D1D1D1);
            dma(1'h1, 8'h55, 32'h0B0B0B05, 0, q, st);
         end
      join
      chk_w(q2, f_init(8'h55));
      dma(1'h0, 8'h13, 32'h00000000, 0, q, st);
      chk_w(q, 32'hD1D1D1D1);
      cpu_op(1'h0, 8'h55, 32'h00000000, q, lat);
      chk_w(q, 32'h0B0B0B05);
   endtask : t_alloc_evict
   task automatic t_wbinv_modes;
      l1dc_word_t q;
      int lat;
      cpu_op(1'h1, 8'h96, 32'hC6C6C6C6, q, lat);
      wbinv(5'h00, 1'h0, lat);
      chk_lat(lat, 0, 8);
      wbinv(5'h10, 1'h1, lat);
      chk_lat(lat, 2, 700);
      @(negedge clk);
      l1_all_ram = 1'h1;
      cpu_op(1'h0, 8'h96, 32'h00000000, q, lat);
      chk_w(q, 32'hC6C6C6C6);
      cpu_op(1'h1, 8'hE0, 32'hE0E0E0E0, q, lat);
      cpu_op(1'h0, 8'hE0, 32'h00000000, q, lat);
      chk_w(q, 32'hE0E0E0E0);
      chk_lat(lat, 0, 15);
      @(negedge clk);
      l1_all_ram = 1'h0;
      cpu_op(1'h0, 8'h55, 32'h00000000, q, lat);
      chk_lat(lat, 16, 40);
      chk_w(q, 32'h0B0B0B05);
   endtask : t_wbinv_modes
   task automatic t_err_wmiss;
      l1dc_word_t q;
      logic [1:0] st;
      int lat;
      @(negedge clk);
      l2_all_cache = 1'h1;
      dma(1'h0, 8'h20, 32'h00000000, 0, q, st);
      chk_f({2'h0, st}, 4'h2);
      dma(1'h1, 8'h20, 32'h12345678, 1, q, st);
      chk_f({2'h0, st}, 4'h2);
      @(negedge clk);
      l2_all_cache = 1'h0;
      cpu_op(1'h1, 8'hE4, 32'hE4E4E4E4, q, lat);
      chk_lat(lat, 0, 20);
      cpu_op(1'h0, 8'hE4, 32'h00000000, q, lat);
      chk_lat(lat, 16, 40);
      chk_w(q, 32'hE4E4E4E4);
   endtask : t_err_wmiss
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(negedge clk);
      nrst = 1'h1;
      chk_f({cpu_rvalid, dma_rvalid | dma_err, wbinv_done, wbinv_busy},
         4'h0);
      t_load();
      t_alloc_evict();
      t_wbinv_modes();
      t_err_wmiss();
      stop_test();
   end
endmodule : tb
